/* File: rcwar_regs.sv */
// Serial-port register bank: thresholds, wake-up status and analog control.
// Notes on behaviour
// - High threshold, seven bits, sets matched chips needed to judge a one.
// - A perfect one gives a count equal to the code length, 64 or 32.
// - High threshold 0x38 with 64 chips tolerates eight bad chips.
// - One decisions come from the high threshold alone, zero decisions from the low threshold alone.
// - Low threshold, seven bits, sets the most matched chips allowed for a zero.
// - A wake-up event follows power-down release once the port is ready.
// - Wake enable bit 0 gates the wake-up interrupt.
// - Wake status bit 0 shows a pending wake-up; upper bits read zero.
// - The interrupt request rises when a wake-up condition occurs.
// - Reading the wake status register clears the pending flag.
// - Analog bit 6 unlocks writes to the two trim registers.
// - Analog bit 5 gates reads of the identifier registers.
// - Analog bit 2 enables the amplifier control pin.
// - Analog bit 1 selects amplifier pin polarity, one meaning active low.
// - Writing one to analog bit 0 restores defaults and clears itself.
`timescale 1ns/1ps
`include "rcwar_map.svh"
module rcwar_regs #(
  parameter int          READY_CYCLES = `RCWAR_READY_CYCLES,
  parameter int          CHIPS        = `RCWAR_CODE_LEN,
  parameter logic [31:0] MID_VALUE    = 32'h0000_0000 // Arbitrary value.
) (
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic                     spi_sck,
  input  wire logic                     spi_mosi,
  input  wire logic                     spi_ss_n,
  output logic                          spi_miso,
  output logic                          spi_miso_oe,
  input  wire logic                     power_down_pin,
  output logic                          irq,
  input  wire logic                     tx_amp_request,
  output logic                          ext_amp_control_pin,
  output logic                          ext_amp_control_oe,
  output logic                          mid_power_on,
  output rcwar_pkg::rcwar_trim_t        trim_regs,
  input  wire logic                     chip_strobe,
  input  wire logic [CHIPS-1:0]         rx_chips,
  input  wire logic [CHIPS-1:0]         spreading_code,
  input  wire logic                     short_code,
  output logic                          bit_valid,
  output logic                          bit_one,
  output logic                          bit_zero
);
  import rcwar_pkg::*;

  logic           sck_m, sck_s, sck_p, mosi_m, mosi_s, ss_m, ss_s;
  logic           pd_m, pd_s;
  rcwar_wake_st_t wake_st_q;
  logic [15:0]    ready_cnt_q;
  logic           wake_set;
  logic           spi_ready;
  logic           active, sck_rise, sck_fall;
  logic [7:0]     rx_sh_q, rx_byte;
  logic [2:0]     bit_cnt_q;
  logic           hdr_done_q, is_write_q, inc_q;
  logic [5:0]     addr_q;
  logic           byte_done, wr_en, rd_en;
  logic [5:0]     rd_addr;
  logic [7:0]     rd_data, tx_sh_q;
  rcwar_thresh_t  thresh_q;
  logic           wake_en_q, wake_pend_q, soft_rst_q;
  rcwar_analog_t  analog_q;
  rcwar_trim_t    trim_q;

  // Identifier registers occupy the last four offsets of the map.
  function automatic logic is_mid(input logic [5:0] a);
    return a[5:2] == `RCWAR_MID_PAGE;
  endfunction

  // Pins arrive from another domain, so each passes two flip-flops first.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {sck_m, sck_s, sck_p} <= 3'h0;
      {mosi_m, mosi_s}      <= 2'h0;
      {ss_m, ss_s}          <= 2'h3;
      {pd_m, pd_s}          <= 2'h0;
    end else begin
      {sck_m, sck_s, sck_p} <= {spi_sck, sck_m, sck_s};
      {mosi_m, mosi_s}      <= {spi_mosi, mosi_m};
      {ss_m, ss_s}          <= {spi_ss_n, ss_m};
      {pd_m, pd_s}          <= {power_down_pin, pd_m};
    end
  end

  // The port is not ready until the release delay has passed.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wake_st_q   <= RCWAR_WK_UP;
      ready_cnt_q <= 16'h0000;
    end else begin
      case (wake_st_q)
        RCWAR_WK_UP: begin
          if (pd_s) begin
            wake_st_q <= RCWAR_WK_DOWN;
          end
        end
        RCWAR_WK_DOWN: begin
          ready_cnt_q <= 16'h0000;
          if (!pd_s) begin
            wake_st_q <= RCWAR_WK_WAIT;
          end
        end
        RCWAR_WK_WAIT: begin
          if (pd_s) begin
            wake_st_q <= RCWAR_WK_DOWN;
          end else if (ready_cnt_q == 16'(READY_CYCLES - 1)) begin
            wake_st_q <= RCWAR_WK_UP;
          end else begin
            ready_cnt_q <= ready_cnt_q + 16'h0001;
          end
        end
        default: begin
          wake_st_q <= RCWAR_WK_DOWN;
        end
      endcase
    end
  end

  assign wake_set  = wake_st_q == RCWAR_WK_WAIT && !pd_s
                     && ready_cnt_q == 16'(READY_CYCLES - 1);
  assign spi_ready = wake_st_q == RCWAR_WK_UP;
  assign active    = !ss_s && spi_ready;
  assign sck_rise  = active && sck_s && !sck_p;
  assign sck_fall  = active && !sck_s && sck_p;
  assign rx_byte   = {rx_sh_q[6:0], mosi_s};
  assign byte_done = sck_rise && bit_cnt_q == `RCWAR_LAST_BIT;

  // Decode of a completed byte into a write or a read-ahead of the next byte.
  always_comb begin
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    rd_addr = addr_q;
    if (byte_done) begin
      if (!hdr_done_q) begin
        rd_en   = !rx_byte[`RCWAR_HDR_WRITE];
        rd_addr = rx_byte[5:0];
      end else if (is_write_q) begin
        wr_en = 1'b1;
      end else begin
        rd_en   = 1'b1;
        rd_addr = inc_q ? addr_q + 6'h01 : addr_q;
      end
    end
  end

  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      `RCWAR_ADDR_THR_LOW:  rd_data = {1'b0, thresh_q.thr_low};
      `RCWAR_ADDR_THR_HIGH: rd_data = {1'b0, thresh_q.thr_high};
      `RCWAR_ADDR_WAKE_EN:  rd_data = {7'h00, wake_en_q};
      `RCWAR_ADDR_WAKE_ST:  rd_data = {7'h00, wake_pend_q};
      `RCWAR_ADDR_ANALOG:   rd_data = {1'b0, analog_q.reg_write_en,
                                       analog_q.mid_read_en, 2'h0,
                                       analog_q.amp_control_output_on,
                                       analog_q.amp_control_polarity, 1'b0};
      `RCWAR_ADDR_TRIM_LO:  rd_data = trim_q.trim_lo;
      `RCWAR_ADDR_TRIM_HI:  rd_data = trim_q.trim_hi;
      default: begin
        if (is_mid(rd_addr) && analog_q.mid_read_en) begin
          rd_data = MID_VALUE[8*rd_addr[1:0] +: 8];
        end
      end
    endcase
  end

  // Serial shifter: mode 0, most significant bit first.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_sh_q    <= 8'h00;
      bit_cnt_q  <= 3'h0;
      hdr_done_q <= 1'b0;
      is_write_q <= 1'b0;
      inc_q      <= 1'b0;
      addr_q     <= 6'h00;
    end else if (!active) begin
      bit_cnt_q  <= 3'h0;
      hdr_done_q <= 1'b0;
    end else if (sck_rise) begin
      rx_sh_q   <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done && !hdr_done_q) begin
        hdr_done_q <= 1'b1;
        is_write_q <= rx_byte[`RCWAR_HDR_WRITE];
        inc_q      <= rx_byte[`RCWAR_HDR_INC];
        addr_q     <= rx_byte[5:0];
      end else if (byte_done && inc_q) begin
        addr_q <= addr_q + 6'h01;
      end
    end
  end

  // The first bit must stand before the next rising edge, so no shift follows
  // the rising edge that completed a byte.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_sh_q     <= 8'h00;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= active;
      if (rd_en) begin
        tx_sh_q <= rd_data;
      end else if (sck_fall && bit_cnt_q != 3'h0) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end
  assign spi_miso = tx_sh_q[7];

  // Writable registers; reserved bits are simply not stored.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      thresh_q   <= '{`RCWAR_RST_THR_HIGH, `RCWAR_RST_THR_LOW};
      wake_en_q  <= `RCWAR_RST_WAKE_EN;
      analog_q   <= '0;
      trim_q     <= '{trim_hi: `RCWAR_RST_TRIM, trim_lo: `RCWAR_RST_TRIM};
      soft_rst_q <= 1'b0;
    end else if (soft_rst_q) begin
      thresh_q   <= '{`RCWAR_RST_THR_HIGH, `RCWAR_RST_THR_LOW};
      wake_en_q  <= `RCWAR_RST_WAKE_EN;
      analog_q   <= '0;
      trim_q     <= '{trim_hi: `RCWAR_RST_TRIM, trim_lo: `RCWAR_RST_TRIM};
      soft_rst_q <= 1'b0;
    end else if (wr_en) begin
      case (addr_q)
        `RCWAR_ADDR_THR_LOW:  thresh_q.thr_low  <= rx_byte[6:0];
        `RCWAR_ADDR_THR_HIGH: thresh_q.thr_high <= rx_byte[6:0];
        `RCWAR_ADDR_WAKE_EN:  wake_en_q <= rx_byte[0];
        `RCWAR_ADDR_ANALOG: begin
          analog_q.reg_write_en <= rx_byte[`RCWAR_AN_REG_WR];
          analog_q.mid_read_en  <= rx_byte[`RCWAR_AN_MID_RD];
          analog_q.amp_control_output_on <= rx_byte[`RCWAR_AN_AMP_ON];
          analog_q.amp_control_polarity  <= rx_byte[`RCWAR_AN_AMP_INV];
          soft_rst_q <= rx_byte[`RCWAR_AN_SOFT_RST];
        end
        `RCWAR_ADDR_TRIM_LO: begin
          if (analog_q.reg_write_en) begin
            trim_q.trim_lo <= rx_byte;
          end
        end
        `RCWAR_ADDR_TRIM_HI: begin
          if (analog_q.reg_write_en) begin
            trim_q.trim_hi <= rx_byte;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // A wake-up arriving in the cycle of a status read is kept pending.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wake_pend_q <= `RCWAR_RST_WAKE_ST;
      irq         <= 1'b0;
    end else begin
      if (wake_set || soft_rst_q) begin
        wake_pend_q <= 1'b1;
      end else if (rd_en && rd_addr == `RCWAR_ADDR_WAKE_ST) begin
        wake_pend_q <= 1'b0;
      end
      irq <= wake_en_q && wake_pend_q;
    end
  end

  // Enable and polarity are applied together; the host keeps them apart.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_amp_control_pin <= 1'b0;
      ext_amp_control_oe  <= 1'b0;
      mid_power_on        <= 1'b0;
    end else begin
      ext_amp_control_oe  <= analog_q.amp_control_output_on;
      ext_amp_control_pin <= analog_q.amp_control_output_on
        && (tx_amp_request ^ analog_q.amp_control_polarity);
      mid_power_on        <= analog_q.mid_read_en;
    end
  end
  assign trim_regs = trim_q;

  rcwar_corr #(
    .CHIPS(CHIPS)
  ) u_corr (
    .ref_clk        (ref_clk),
    .resetn         (resetn),
    .chip_strobe    (chip_strobe),
    .rx_chips       (rx_chips),
    .spreading_code (spreading_code),
    .short_code     (short_code),
    .thresh         (thresh_q),
    .bit_valid      (bit_valid),
    .bit_one        (bit_one),
    .bit_zero       (bit_zero),
    .match_count    ()
  );

  sequence s_status_read;
    rd_en && rd_addr == `RCWAR_ADDR_WAKE_ST && !wake_set && !soft_rst_q;
  endsequence

  a_status_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_status_read ##1 !wake_set [*1] |-> !wake_pend_q ##1 !irq)
    else $error("Status read did not clear the pending flag.");

  a_wake_event: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(spi_ready) |-> $past(wake_set) ##0 wake_pend_q)
    else $error("Port became ready without a pending wake-up.");

  a_irq_gated: assert property (@(posedge ref_clk) disable iff (!resetn)
    irq |-> $past(wake_en_q) && $past(wake_pend_q))
    else $error("Interrupt raised without enable and pending flag.");

  a_irq_raise: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wake_set && wake_en_q && !soft_rst_q && !wr_en) |=> ##1 irq)
    else $error("Enabled wake-up did not raise the interrupt.");

  a_trim_locked: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wr_en && !analog_q.reg_write_en && !soft_rst_q) |=> $stable(trim_q))
    else $error("Locked trim register accepted a write.");

  a_mid_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    (rd_en && is_mid(rd_addr) && !analog_q.mid_read_en) |=> tx_sh_q == 8'h00)
    else $error("Identifier read while the gate is closed.");

  a_soft_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
    soft_rst_q |=> thresh_q.thr_high == `RCWAR_RST_THR_HIGH
      && thresh_q.thr_low == `RCWAR_RST_THR_LOW && analog_q == '0
      && !soft_rst_q && wake_pend_q)
    else $error("Soft reset did not restore the defaults.");

  a_amp_pin: assert property (@(posedge ref_clk) disable iff (!resetn)
    ##1 ext_amp_control_oe == $past(analog_q.amp_control_output_on)
      && (!ext_amp_control_oe -> !ext_amp_control_pin))
    else $error("Amplifier pin enable does not follow its bit.");

  a_amp_polarity: assert property (@(posedge ref_clk) disable iff (!resetn)
    (analog_q.amp_control_output_on && analog_q.amp_control_polarity
      && !tx_amp_request) |=> ext_amp_control_pin)
    else $error("Active-low amplifier pin not high when idle.");
endmodule

/* File: rcwar_map.svh */
// Register offsets, field positions, reset values and counts of the register bank.
`ifndef RCWAR_MAP_SVH
`define RCWAR_MAP_SVH
`define RCWAR_ADDR_THR_LOW    6'h19
`define RCWAR_ADDR_THR_HIGH   6'h1a
`define RCWAR_ADDR_WAKE_EN    6'h1c
`define RCWAR_ADDR_WAKE_ST    6'h1d
`define RCWAR_ADDR_ANALOG     6'h20
`define RCWAR_ADDR_TRIM_LO    6'h2e
`define RCWAR_ADDR_TRIM_HI    6'h2f
`define RCWAR_MID_PAGE        4'hf
`define RCWAR_RST_THR_LOW     7'h08
`define RCWAR_RST_THR_HIGH    7'h38
`define RCWAR_RST_WAKE_EN     1'b0
`define RCWAR_RST_WAKE_ST     1'b1
`define RCWAR_RST_TRIM        8'h00
`define RCWAR_AN_REG_WR       6
`define RCWAR_AN_MID_RD       5
`define RCWAR_AN_AMP_ON       2
`define RCWAR_AN_AMP_INV      1
`define RCWAR_AN_SOFT_RST     0
`define RCWAR_HDR_WRITE       7
`define RCWAR_HDR_INC         6
`define RCWAR_LAST_BIT        3'h7
`define RCWAR_READY_CYCLES    16
`define RCWAR_CODE_LEN        64
`define RCWAR_COUNT_W         7
`endif

/* File: rcwar_pkg.sv */
// Types shared by the register bank and its correlator decision stage.
package rcwar_pkg;
  typedef struct packed {
    logic [6:0] thr_high;
    logic [6:0] thr_low;
  } rcwar_thresh_t;

  typedef struct packed {
    logic reg_write_en;
    logic mid_read_en;
    logic amp_control_output_on;
    logic amp_control_polarity;
  } rcwar_analog_t;

  typedef struct packed {
    logic [7:0] trim_hi;
    logic [7:0] trim_lo;
  } rcwar_trim_t;

  typedef enum logic [1:0] {
    RCWAR_WK_DOWN,
    RCWAR_WK_WAIT,
    RCWAR_WK_UP
  } rcwar_wake_st_t;
endpackage

/* File: rcwar_corr.sv */
// Correlator decision: counts matched chips and judges one, zero or erased.
`timescale 1ns/1ps
`include "rcwar_map.svh"
module rcwar_corr #(
  parameter int CHIPS = `RCWAR_CODE_LEN
) (
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  input  wire logic                        chip_strobe,
  input  wire logic [CHIPS-1:0]            rx_chips,
  input  wire logic [CHIPS-1:0]            spreading_code,
  input  wire logic                        short_code,
  input  wire rcwar_pkg::rcwar_thresh_t    thresh,
  output logic                             bit_valid,
  output logic                             bit_one,
  output logic                             bit_zero,
  output logic [`RCWAR_COUNT_W-1:0]        match_count
);
  import rcwar_pkg::*;

  logic [`RCWAR_COUNT_W-1:0] count_d;

  // A short code uses only the lower half of the chip window.
  function automatic logic [`RCWAR_COUNT_W-1:0] count_matches(
    input logic [CHIPS-1:0] rx,
    input logic [CHIPS-1:0] code,
    input logic             half
  );
    logic [`RCWAR_COUNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < CHIPS; i++) begin
      if ((!half || i < CHIPS / 2) && rx[i] == code[i]) begin
        n = n + 1'b1;
      end
    end
    return n;
  endfunction

  assign count_d = count_matches(rx_chips, spreading_code, short_code);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bit_valid   <= 1'b0;
      bit_one     <= 1'b0;
      bit_zero    <= 1'b0;
      match_count <= '0;
    end else begin
      bit_valid <= chip_strobe;
      if (chip_strobe) begin
        match_count <= count_d;
        bit_one     <= count_d >= thresh.thr_high;
        bit_zero    <= count_d <= thresh.thr_low;
      end
    end
  end

  a_one_decision: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    chip_strobe |=> bit_one == (match_count >= $past(thresh.thr_high)))
    else $error("One decision does not follow the high threshold.");

  a_zero_decision: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    chip_strobe |=> bit_zero == (match_count <= $past(thresh.thr_low)))
    else $error("Zero decision does not follow the low threshold.");

  a_perfect_one: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (chip_strobe && rx_chips == spreading_code && !short_code)
      |=> match_count == `RCWAR_COUNT_W'(CHIPS))
    else $error("Perfect long code does not give a full count.");
endmodule

/* File: rcwar_host.sv */
// Host model: serial port master that frames register reads and writes.
`timescale 1ns/1ps
`include "rcwar_map.svh"
module rcwar_host (
  output logic      spi_sck,
  output logic      spi_mosi,
  output logic      spi_ss_n,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  logic [7:0] an_q;

  initial begin
    spi_sck  = 1'b0;
    spi_mosi = 1'b0;
    spi_ss_n = 1'b1;
    an_q     = 8'h00;
  end

  // The odd offset keeps the serial clock unrelated in phase to ref_clk.
  task automatic frame(input logic [23:0] sh, input int nbits,
                       output logic [15:0] rd);
    rd = 16'h0000;
    #1.3;
    spi_ss_n = 1'b0;
    for (int i = 23; i >= 24 - nbits; i--) begin
      spi_mosi = sh[i];
      #24;
      spi_sck = 1'b1;
      rd = {rd[14:0], spi_miso_oe ? spi_miso : 1'bx};
      #24;
      spi_sck = 1'b0;
    end
    #24;
    spi_ss_n = 1'b1;
    // A released data line must not keep showing the last bit.
    spi_mosi = ~spi_mosi;
    #150;
  endtask

  task automatic xfer(input logic [7:0] hdr, input logic [7:0] dat,
                      output logic [7:0] rd);
    logic [15:0] r;
    frame({hdr, dat, 8'h00}, 16, r);
    rd = r[7:0];
  endtask

  // Auto-increment frames carry two data bytes; used on the threshold pair.
  task automatic burst_write(input logic [5:0] a, input logic [7:0] d0,
                             input logic [7:0] d1);
    logic [15:0] r;
    frame({2'b11, a, d0 & 8'h7f, d1 & 8'h7f}, 24, r);
  endtask

  task automatic burst_read(input logic [5:0] a, output logic [7:0] d0,
                            output logic [7:0] d1);
    logic [15:0] r;
    frame({2'b01, a, 16'h0000}, 24, r);
    {d0, d1} = r;
  endtask

  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] m;
    logic [7:0] v;
    logic [7:0] rd;
    case (a)
      `RCWAR_ADDR_THR_LOW, `RCWAR_ADDR_THR_HIGH: m = 8'h7f;
      `RCWAR_ADDR_WAKE_EN: m = 8'h01;
      `RCWAR_ADDR_ANALOG: m = 8'h67;
      default: m = 8'hff;
    endcase
    v = d & m;
    // Enable and polarity never move together; split into two writes.
    if (a == `RCWAR_ADDR_ANALOG && v[2] != an_q[2] && v[1] != an_q[1]) begin
      xfer({2'b10, a}, {v[7:2], an_q[1], 1'b0}, rd);
    end
    xfer({2'b10, a}, v, rd);
    if (a == `RCWAR_ADDR_ANALOG) begin
      an_q = v[0] ? 8'h00 : v;
    end
  endtask

  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    xfer({2'b00, a}, 8'h00, d);
  endtask
endmodule

/* File: rcwar_regs_test.sv */
// Self-checking bench for the register bank, driven through the host model.
`timescale 1ns/1ps
`include "rcwar_map.svh"
module rcwar_regs_test;
  import rcwar_pkg::*;
  localparam logic [31:0] MIDV = 32'h5a3c_96e1; // Arbitrary value.
  localparam logic [63:0] CODE = 64'hf0e1_d2c3_b4a5_9687;
  logic          ref_clk = 1'b0;
  logic          resetn;
  logic          spi_sck;
  logic          spi_mosi;
  logic          spi_ss_n;
  logic          spi_miso;
  logic          spi_miso_oe;
  logic          power_down_pin;
  logic          irq;
  logic          tx_amp_request;
  logic          ext_amp_control_pin;
  logic          ext_amp_control_oe;
  logic          mid_power_on;
  rcwar_trim_t   trim_regs;
  logic          chip_strobe;
  logic [63:0]   rx_chips;
  logic          short_code;
  logic          bit_valid;
  logic          bit_one;
  logic          bit_zero;
  int            errors = 0;
  int            n_compared = 0;

  always #2 ref_clk = ~ref_clk;

  rcwar_regs #(.READY_CYCLES(4), .MID_VALUE(MIDV)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_ss_n(spi_ss_n), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .power_down_pin(power_down_pin),
    .irq(irq), .tx_amp_request(tx_amp_request),
    .ext_amp_control_pin(ext_amp_control_pin),
    .ext_amp_control_oe(ext_amp_control_oe), .mid_power_on(mid_power_on),
    .trim_regs(trim_regs), .chip_strobe(chip_strobe),
    .rx_chips(rx_chips), .spreading_code(CODE), .short_code(short_code),
    .bit_valid(bit_valid), .bit_one(bit_one), .bit_zero(bit_zero)
  );

  rcwar_host u_host (
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_ss_n(spi_ss_n),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe)
  );

  task automatic check8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] a,
                        input logic [7:0] e);
    logic [7:0] v;
    u_host.reg_read(a, v);
    check8(nm, e, v);
  endtask

  task automatic corr(input logic [63:0] rx, input logic sc,
                      input logic e1, input logic e0);
    @(posedge ref_clk);
    rx_chips <= rx;
    short_code <= sc;
    chip_strobe <= 1'b1;
    @(posedge ref_clk);
    chip_strobe <= 1'b0;
    #1;
    check1("bit_valid", 1'b1, bit_valid);
    check1("bit_one", e1, bit_one);
    check1("bit_zero", e0, bit_zero);
    @(posedge ref_clk);
    #1;
    check1("bit_valid end", 1'b0, bit_valid);
  endtask

  task automatic pd_pulse();
    @(posedge ref_clk);
    power_down_pin <= 1'b1;
    repeat (20) @(posedge ref_clk);
    power_down_pin <= 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    check1("irq", 1'b0, irq);
    rd_chk("high thr", `RCWAR_ADDR_THR_HIGH, 8'h38);
    rd_chk("low thr", `RCWAR_ADDR_THR_LOW, 8'h08);
    rd_chk("wake en", `RCWAR_ADDR_WAKE_EN, 8'h00);
    rd_chk("analog", `RCWAR_ADDR_ANALOG, 8'h00);
    rd_chk("wake st", `RCWAR_ADDR_WAKE_ST, 8'h01);
    rd_chk("wake st clr", `RCWAR_ADDR_WAKE_ST, 8'h00);
    rd_chk("unmapped", 6'h30, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_corr();
    u_host.reg_write(`RCWAR_ADDR_THR_HIGH, 8'h39);
    rd_chk("high thr", `RCWAR_ADDR_THR_HIGH, 8'h39);
    corr(CODE ^ 64'hff, 1'b0, 1'b0, 1'b0);
    u_host.reg_write(`RCWAR_ADDR_THR_HIGH, 8'h38);
    corr(CODE ^ 64'hff, 1'b0, 1'b1, 1'b0);
    corr(CODE ^ 64'h1ff, 1'b0, 1'b0, 1'b0);
    corr(CODE, 1'b0, 1'b1, 1'b0);
    corr(~CODE ^ 64'hff, 1'b0, 1'b0, 1'b1);
    corr(~CODE ^ 64'h1ff, 1'b0, 1'b0, 1'b0);
    // Upper chips are inverted: a short code must ignore them.
    corr({~CODE[63:32], CODE[31:0]}, 1'b1, 1'b0, 1'b0);
    u_host.reg_write(`RCWAR_ADDR_THR_HIGH, 8'h20);
    corr({~CODE[63:32], CODE[31:0]}, 1'b1, 1'b1, 1'b0);
    u_host.reg_write(`RCWAR_ADDR_THR_HIGH, 8'h38);
    $display("test correlator done");
  endtask

  task automatic t_wake();
    pd_pulse();
    check1("irq off", 1'b0, irq);
    rd_chk("wake st", `RCWAR_ADDR_WAKE_ST, 8'h01);
    u_host.reg_write(`RCWAR_ADDR_WAKE_EN, 8'h01);
    rd_chk("wake en", `RCWAR_ADDR_WAKE_EN, 8'h01);
    check1("irq idle", 1'b0, irq);
    pd_pulse();
    check1("irq on", 1'b1, irq);
    rd_chk("wake st", `RCWAR_ADDR_WAKE_ST, 8'h01);
    check1("irq clr", 1'b0, irq);
    rd_chk("wake st clr", `RCWAR_ADDR_WAKE_ST, 8'h00);
    $display("test wake done");
  endtask

  task automatic t_trim_mid();
    u_host.reg_write(`RCWAR_ADDR_TRIM_LO, 8'h5a);
    check8("trim lo locked", 8'h00, trim_regs.trim_lo);
    u_host.reg_write(`RCWAR_ADDR_ANALOG, 8'h40);
    u_host.reg_write(`RCWAR_ADDR_TRIM_LO, 8'h5a);
    u_host.reg_write(`RCWAR_ADDR_TRIM_HI, 8'ha5);
    check8("trim lo", 8'h5a, trim_regs.trim_lo);
    rd_chk("trim hi", `RCWAR_ADDR_TRIM_HI, 8'ha5);
    rd_chk("mid gated", 6'h3c, 8'h00);
    u_host.reg_write(`RCWAR_ADDR_ANALOG, 8'h60);
    check1("mid power", 1'b1, mid_power_on);
    rd_chk("mid 0", 6'h3c, MIDV[7:0]);
    rd_chk("mid 3", 6'h3f, MIDV[31:24]);
    // The identifier draws power, so the gate is dropped at once.
    u_host.reg_write(`RCWAR_ADDR_ANALOG, 8'h40);
    check1("mid power off", 1'b0, mid_power_on);
    $display("test trim and identifier done");
  endtask

  task automatic t_amp();
    u_host.reg_write(`RCWAR_ADDR_ANALOG, 8'h44);
    check1("amp oe", 1'b1, ext_amp_control_oe);
    check1("amp pin", 1'b1, ext_amp_control_pin);
    u_host.reg_write(`RCWAR_ADDR_ANALOG, 8'h46);
    check1("amp pin inv", 1'b0, ext_amp_control_pin);
    @(posedge ref_clk);
    tx_amp_request <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check1("amp pin idle", 1'b1, ext_amp_control_pin);
    u_host.reg_write(`RCWAR_ADDR_ANALOG, 8'h40);
    check1("amp oe off", 1'b0, ext_amp_control_oe);
    check1("amp pin off", 1'b0, ext_amp_control_pin);
    $display("test amplifier done");
  endtask

  task automatic t_burst();
    logic [7:0] d0;
    logic [7:0] d1;
    u_host.burst_write(`RCWAR_ADDR_THR_LOW, 8'h0a, 8'h30);
    u_host.burst_read(`RCWAR_ADDR_THR_LOW, d0, d1);
    check8("burst low thr", 8'h0a, d0);
    check8("burst high thr", 8'h30, d1);
    $display("test burst done");
  endtask

  task automatic t_soft();
    u_host.reg_write(`RCWAR_ADDR_THR_HIGH, 8'h11);
    u_host.reg_write(`RCWAR_ADDR_ANALOG, 8'h41);
    rd_chk("analog", `RCWAR_ADDR_ANALOG, 8'h00);
    check8("trim hi", 8'h00, trim_regs.trim_hi);
    check1("irq", 1'b0, irq);
    rd_chk("high thr", `RCWAR_ADDR_THR_HIGH, 8'h38);
    rd_chk("low thr", `RCWAR_ADDR_THR_LOW, 8'h08);
    rd_chk("wake en", `RCWAR_ADDR_WAKE_EN, 8'h00);
    rd_chk("wake st", `RCWAR_ADDR_WAKE_ST, 8'h01);
    $display("test soft reset done");
  endtask

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    power_down_pin = 1'b0;
    tx_amp_request = 1'b1;
    chip_strobe = 1'b0;
    rx_chips = 64'h0;
    short_code = 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge ref_clk);
    t_reset();
    t_corr();
    t_wake();
    t_trim_mid();
    t_amp();
    t_burst();
    t_soft();
    test_done();
  end

  // About forty frames of roughly one microsecond each; allow ample margin.
  initial begin
    #300000;
    errors++;
    test_done();
  end
endmodule
